// ### edrc_core.sv
/*
 * Eight-channel request core: flow control, fixed-priority arbitration, interrupt status.
 * Assumes master and peripherals on core_clk; master ends each mst_req with one mst_done.
 */
// Function
// RQ1: Slave error finishes chunk, then disables channel
// RQ2: Error interrupt raised, maskable by software
// RQ3: Private state per channel
// RQ4: Fixed priority, channel 0 highest, 7 lowest
// RQ5: Switch only after delegated quadword completes
// RQ6: Software puts memory copies on channel 7
// RQ7: One interrupt output ORs all requests
// RQ8: Lanes 0-5 burst+single, 6-9 burst, rest reserved
// RQ9: Copy channels skip the handshake
// RQ10: Burst request moves programmed burst count
// RQ11: Single request moves exactly one item
// RQ12: Last-burst and last-single lines end packet
// RQ13: Acknowledge line pulses when request completes
// RQ14: Terminal-count line pulses when transfer finishes
// RQ15: Eight channels plus global status registers
// RQ16: Masked interrupt status at 0x000, reset zero
// RQ17: Masked tc/error status at 0x004/0x00c
// RQ18: Write-only clears at 0x008 and 0x010
// RQ19: Raw tc/error status at 0x014/0x018
// RQ20: Enabled channels readable at 0x01c
// RQ21: Software burst/single/last-burst request registers
// RQ22: Masked status bits 7:0 per channel
// RQ23: Software request acts as line, cleared on ack
// RQ24: Raw flags set on completion and error
`timescale 1ns/1ps
module edrc_core
    import edrc_pkg::*;
#(
    parameter int CNT_W = EDRC_CNT_W
)
(
    input wire logic core_clk,
    input wire logic rstn,
    edrc_if.dev link,
    input wire logic [11:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    input wire logic [7:0] ch_start,
    input wire logic [CNT_W-1:0] ch_count,
    input wire logic [3:0] ch_periph,
    input wire logic ch_m2m,
    input wire logic [3:0] ch_burst_len,
    input wire logic [7:0] tc_mask,
    input wire logic [7:0] err_mask,
    output logic mst_req,
    output logic [2:0] mst_ch,
    output logic [2:0] mst_len,
    input wire logic mst_done,
    input wire logic mst_err,
    output logic dma_irq
);

    // *********************************************
    // Channel, arbiter and register state
    // *********************************************
    // Private state per channel; data FIFO sits in the master
    logic [7:0] act_r; // RQ3 RQ15
    logic [7:0] m2m_r;
    logic [7:0] in_req_r;
    logic [7:0] last_r;
    logic [7:0] hold_r;
    logic [CNT_W-1:0] rem_r [EDRC_NCH];
    logic [CNT_W-1:0] req_left_r [EDRC_NCH];
    logic [3:0] periph_r [EDRC_NCH];
    logic [3:0] blen_r [EDRC_NCH];
    edrc_arb_t state_r;
    logic mst_req_r;
    logic [2:0] mst_ch_r;
    logic [2:0] mst_len_r;
    logic [7:0] raw_tc_r;
    logic [7:0] raw_err_r;
    logic [15:0] soft_b_r;
    logic [15:0] soft_s_r;
    logic [15:0] soft_lb_r;
    logic [15:0] ack_r;
    logic [15:0] tc_r;
    logic [31:0] rdata_r;
    logic irq_r;

    // *********************************************
    // Request decode
    // *********************************************
    wire logic [15:0] any_b = (link.burst_request_lines | soft_b_r) & EDRC_BURST_OK; // RQ8 RQ23
    wire logic [15:0] any_lb = (link.last_burst_request_lines | soft_lb_r) & EDRC_BURST_OK; // RQ8 RQ23
    wire logic [15:0] any_s = (link.single_request_lines | soft_s_r) & EDRC_SINGLE_OK; // RQ8 RQ23
    wire logic [15:0] any_ls = link.last_single_request_lines & EDRC_SINGLE_OK; // RQ8

    // *********************************************
    // Arbitration
    // *********************************************
    logic [7:0] pend;
    logic [11:0] base;
    logic [11:0] chunk;
    wire logic [2:0] pick = edrc_first(pend); // RQ4
    wire logic [2:0] fc = mst_ch_r;
    wire logic [11:0] flen = {9'h000, mst_len_r};
    wire logic fin = (state_r == EDRC_ARB_BUSY) && mst_done;
    wire logic fin_req = !m2m_r[fc] && (12'(req_left_r[fc]) == flen);
    wire logic fin_all = (12'(rem_r[fc]) == flen) || (fin_req && last_r[fc]);
    wire logic [7:0] fin_oh = 8'h01 << fc;
    wire logic [15:0] fin_lane = 16'h0001 << periph_r[fc];

    always_comb
    begin
        for (int c = 0; c < EDRC_NCH; c++)
        begin
            pend[c] = act_r[c] && (m2m_r[c] || in_req_r[c]); // RQ9
        end
        base = m2m_r[pick] ? 12'(rem_r[pick]) : 12'(req_left_r[pick]);
        // A quadword at most bounds a higher channel's wait
        chunk = edrc_min(edrc_min(base, EDRC_QUAD_ITEMS), 12'(rem_r[pick])); // RQ5
    end

    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            state_r <= EDRC_ARB_IDLE;
            mst_req_r <= 1'b0;
            mst_ch_r <= 3'h0;
            mst_len_r <= 3'h0;
            act_r <= EDRC_CH_RST;
            m2m_r <= EDRC_CH_RST;
            in_req_r <= EDRC_CH_RST;
            last_r <= EDRC_CH_RST;
            hold_r <= EDRC_CH_RST;
            ack_r <= EDRC_LANE_RST;
            tc_r <= EDRC_LANE_RST;
            for (int c = 0; c < EDRC_NCH; c++)
            begin
                rem_r[c] <= '0;
                req_left_r[c] <= '0;
                periph_r[c] <= 4'h0;
                blen_r[c] <= 4'h0;
            end
        end
        else
        begin
            ack_r <= EDRC_LANE_RST;
            tc_r <= EDRC_LANE_RST;
            for (int c = 0; c < EDRC_NCH; c++)
            begin
                hold_r[c] <= 1'b0;
                if (ch_start[c] && !act_r[c] && (ch_count != '0))
                begin
                    act_r[c] <= 1'b1;
                    rem_r[c] <= ch_count;
                    periph_r[c] <= ch_periph;
                    m2m_r[c] <= ch_m2m;
                    blen_r[c] <= (ch_burst_len == 4'h0) ? 4'h1 : ch_burst_len;
                    in_req_r[c] <= 1'b0;
                end
                else if (act_r[c] && !m2m_r[c] && !in_req_r[c] && !hold_r[c])
                begin
                    // Hold skips the stale request cycle
                    if (any_b[periph_r[c]] || any_lb[periph_r[c]])
                    begin
                        in_req_r[c] <= 1'b1;
                        req_left_r[c] <= CNT_W'(blen_r[c]); // RQ10
                        last_r[c] <= any_lb[periph_r[c]]; // RQ12
                    end
                    else if (any_s[periph_r[c]] || any_ls[periph_r[c]])
                    begin
                        in_req_r[c] <= 1'b1;
                        req_left_r[c] <= CNT_W'(EDRC_ONE_ITEM); // RQ11
                        last_r[c] <= any_ls[periph_r[c]]; // RQ12
                    end
                end
            end
            unique case (state_r)
                EDRC_ARB_IDLE:
                begin
                    if (pend != EDRC_CH_RST)
                    begin
                        mst_req_r <= 1'b1;
                        mst_ch_r <= pick; // RQ4
                        mst_len_r <= chunk[2:0];
                        state_r <= EDRC_ARB_BUSY;
                    end
                end
                EDRC_ARB_BUSY:
                begin
                    if (mst_done)
                    begin
                        // Chunk is finished before any switch or shutdown
                        mst_req_r <= 1'b0; // RQ5
                        state_r <= EDRC_ARB_DONE;
                        rem_r[fc] <= rem_r[fc] - CNT_W'(flen);
                        req_left_r[fc] <= req_left_r[fc] - CNT_W'(flen);
                        if (mst_err || fin_all || fin_req)
                        begin
                            in_req_r[fc] <= 1'b0;
                            hold_r[fc] <= 1'b1;
                            if (!m2m_r[fc])
                            begin
                                ack_r <= fin_lane; // RQ13
                            end
                        end
                        if (mst_err || fin_all)
                        begin
                            act_r[fc] <= 1'b0; // RQ1
                        end
                        if (!mst_err && fin_all && !m2m_r[fc])
                        begin
                            tc_r <= fin_lane; // RQ14
                        end
                    end
                end
                EDRC_ARB_DONE:
                begin
                    // Gap lets new requests land before the next pick
                    state_r <= EDRC_ARB_IDLE;
                end
            endcase
        end
    end

    // *********************************************
    // Registers
    // *********************************************
    wire logic [7:0] tc_set = (fin && !mst_err && fin_all) ? fin_oh : EDRC_CH_RST; // RQ24
    wire logic [7:0] err_set = (fin && mst_err) ? fin_oh : EDRC_CH_RST; // RQ24
    wire logic [7:0] tc_clr = (reg_wr && reg_addr == EDRC_TC_REQUEST_CLEAR) ? reg_wdata[7:0] : EDRC_CH_RST;
    wire logic [7:0] err_clr = (reg_wr && reg_addr == EDRC_ERROR_REQUEST_CLEAR) ? reg_wdata[7:0] : EDRC_CH_RST;
    wire logic [7:0] m_tc = raw_tc_r & tc_mask;
    wire logic [7:0] m_err = raw_err_r & err_mask; // RQ2
    wire logic [7:0] m_any = m_tc | m_err; // RQ22
    wire logic wr_b = reg_wr && (reg_addr == EDRC_SOFT_BURST_REQUEST);
    wire logic wr_s = reg_wr && (reg_addr == EDRC_SOFT_SINGLE_REQUEST);
    wire logic wr_lb = reg_wr && (reg_addr == EDRC_SOFT_LAST_BURST_REQUEST);
    logic [31:0] rd_mux;

    always_comb
    begin
        unique case (reg_addr)
            EDRC_MASKED_IRQ_STATUS: rd_mux = {24'h0, m_any}; // RQ16
            EDRC_MASKED_TC_STATUS: rd_mux = {24'h0, m_tc}; // RQ17
            EDRC_MASKED_ERROR_STATUS: rd_mux = {24'h0, m_err}; // RQ17
            EDRC_RAW_TC_STATUS: rd_mux = {24'h0, raw_tc_r}; // RQ19
            EDRC_RAW_ERROR_STATUS: rd_mux = {24'h0, raw_err_r}; // RQ19
            EDRC_ENABLED_CHANNELS: rd_mux = {24'h0, act_r}; // RQ20
            EDRC_SOFT_BURST_REQUEST: rd_mux = {16'h0, soft_b_r}; // RQ21
            EDRC_SOFT_SINGLE_REQUEST: rd_mux = {16'h0, soft_s_r}; // RQ21
            EDRC_SOFT_LAST_BURST_REQUEST: rd_mux = {16'h0, soft_lb_r}; // RQ21
            default: rd_mux = EDRC_WORD_ZERO;
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            raw_tc_r <= EDRC_CH_RST;
            raw_err_r <= EDRC_CH_RST;
            soft_b_r <= EDRC_LANE_RST;
            soft_s_r <= EDRC_LANE_RST;
            soft_lb_r <= EDRC_LANE_RST;
            rdata_r <= EDRC_WORD_ZERO;
            irq_r <= 1'b0;
        end
        else
        begin
            // Hardware set beats a clear in the same cycle
            raw_tc_r <= (raw_tc_r & ~tc_clr) | tc_set; // RQ18 RQ24
            raw_err_r <= (raw_err_r & ~err_clr) | err_set; // RQ18 RQ24
            soft_b_r <= wr_b ? reg_wdata[15:0] : (soft_b_r & ~ack_r); // RQ23
            soft_s_r <= wr_s ? reg_wdata[15:0] : (soft_s_r & ~ack_r); // RQ23
            soft_lb_r <= wr_lb ? reg_wdata[15:0] : (soft_lb_r & ~ack_r); // RQ23
            if (reg_rd)
            begin
                rdata_r <= rd_mux;
            end
            irq_r <= |m_any; // RQ7 RQ2
        end
    end

    assign link.request_acknowledge_lines = ack_r;
    assign link.terminal_count_lines = tc_r;
    assign reg_rdata = rdata_r;
    assign mst_req = mst_req_r;
    assign mst_ch = mst_ch_r;
    assign mst_len = mst_len_r;
    assign dma_irq = irq_r;

endmodule : edrc_core

// ### edrc_if.sv
/*
 * Flow-control link between the request core and its peripherals.
 * Assumes both ends on one clock; no wire is two-way.
 */
`timescale 1ns/1ps
interface edrc_if;
    logic [15:0] burst_request_lines;
    logic [15:0] single_request_lines;
    logic [15:0] last_burst_request_lines;
    logic [15:0] last_single_request_lines;
    logic [15:0] request_acknowledge_lines;
    logic [15:0] terminal_count_lines;

    modport dev (
        input burst_request_lines,
        input single_request_lines,
        input last_burst_request_lines,
        input last_single_request_lines,
        output request_acknowledge_lines,
        output terminal_count_lines
    );

    modport periph (
        output burst_request_lines,
        output single_request_lines,
        output last_burst_request_lines,
        output last_single_request_lines,
        input request_acknowledge_lines,
        input terminal_count_lines
    );
endinterface : edrc_if

// ### edrc_periph.sv
/*
 * Peripheral end: sixteen lanes, each holding its request until acknowledged.
 * Assumes the core on core_clk and levels on want_*.
 */
`timescale 1ns/1ps
module edrc_periph
    import edrc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn,
    edrc_if.periph link,
    input wire logic [15:0] want_burst,
    input wire logic [15:0] want_single,
    input wire logic [15:0] mark_last,
    output logic [15:0] req_done,
    output logic [15:0] tc_seen
);

    // *********************************************
    // Request lanes
    // *********************************************
    logic [15:0] breq_r;
    logic [15:0] sreq_r;
    logic [15:0] lbreq_r;
    logic [15:0] lsreq_r;
    logic [15:0] done_r;
    logic [15:0] tc_r;
    wire logic [15:0] pending = breq_r | sreq_r | lbreq_r | lsreq_r;
    wire logic [15:0] acked = pending & link.request_acknowledge_lines;
    // Lane waits one cycle after its ack before raising anew
    wire logic [15:0] may_raise = ~pending & ~done_r;
    wire logic [15:0] new_burst = may_raise & want_burst;
    wire logic [15:0] new_single = may_raise & ~want_burst & want_single;

    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            breq_r <= EDRC_LANE_RST;
            sreq_r <= EDRC_LANE_RST;
            lbreq_r <= EDRC_LANE_RST;
            lsreq_r <= EDRC_LANE_RST;
            done_r <= EDRC_LANE_RST;
            tc_r <= EDRC_LANE_RST;
        end
        else
        begin
            breq_r <= (breq_r & ~acked) | (new_burst & ~mark_last); // RQ10
            lbreq_r <= (lbreq_r & ~acked) | (new_burst & mark_last); // RQ12
            sreq_r <= (sreq_r & ~acked) | (new_single & ~mark_last); // RQ11
            lsreq_r <= (lsreq_r & ~acked) | (new_single & mark_last); // RQ12
            done_r <= acked;
            tc_r <= acked & link.terminal_count_lines;
        end
    end

    assign link.burst_request_lines = breq_r;
    assign link.single_request_lines = sreq_r;
    assign link.last_burst_request_lines = lbreq_r;
    assign link.last_single_request_lines = lsreq_r;
    assign req_done = done_r;
    assign tc_seen = tc_r;

endmodule : edrc_periph

// ### edrc_pkg.sv
/*
 * Constants and types shared by the request core and its peripheral end.
 * Assumes one clock for both ends and the master.
 */
package edrc_pkg;

    // *********************************************
    // Sizes
    // *********************************************
    localparam int EDRC_NCH = 8;
    localparam int EDRC_CNT_W = 12;

    // *********************************************
    // Register offsets
    // *********************************************
    localparam logic [11:0] EDRC_MASKED_IRQ_STATUS = 12'h000;
    localparam logic [11:0] EDRC_MASKED_TC_STATUS = 12'h004;
    localparam logic [11:0] EDRC_TC_REQUEST_CLEAR = 12'h008;
    localparam logic [11:0] EDRC_MASKED_ERROR_STATUS = 12'h00c;
    localparam logic [11:0] EDRC_ERROR_REQUEST_CLEAR = 12'h010;
    localparam logic [11:0] EDRC_RAW_TC_STATUS = 12'h014;
    localparam logic [11:0] EDRC_RAW_ERROR_STATUS = 12'h018;
    localparam logic [11:0] EDRC_ENABLED_CHANNELS = 12'h01c;
    localparam logic [11:0] EDRC_SOFT_BURST_REQUEST = 12'h020;
    localparam logic [11:0] EDRC_SOFT_SINGLE_REQUEST = 12'h024;
    localparam logic [11:0] EDRC_SOFT_LAST_BURST_REQUEST = 12'h028;

    // *********************************************
    // Reset values and lane capabilities
    // *********************************************
    localparam logic [7:0] EDRC_CH_RST = 8'h00;
    localparam logic [15:0] EDRC_LANE_RST = 16'h0000;
    localparam logic [31:0] EDRC_WORD_ZERO = 32'h00000000;
    localparam logic [15:0] EDRC_BURST_OK = 16'h03ff;
    localparam logic [15:0] EDRC_SINGLE_OK = 16'h003f;
    localparam logic [11:0] EDRC_QUAD_ITEMS = 12'h004;
    localparam logic [11:0] EDRC_ONE_ITEM = 12'h001;
    localparam logic [11:0] EDRC_NO_ITEMS = 12'h000;

    typedef enum logic [2:0] {
        EDRC_ARB_IDLE = 3'b001,
        EDRC_ARB_BUSY = 3'b010,
        EDRC_ARB_DONE = 3'b100
    } edrc_arb_t;

    function automatic logic [2:0] edrc_first(input logic [7:0] v);
        logic [2:0] idx;
        idx = 3'h0;
        for (int i = EDRC_NCH - 1; i >= 0; i--)
        begin
            if (v[i])
            begin
                idx = i[2:0];
            end
        end
        return idx;
    endfunction : edrc_first

    function automatic logic [11:0] edrc_min(input logic [11:0] a, input logic [11:0] b);
        return (a < b) ? a : b;
    endfunction : edrc_min

endpackage : edrc_pkg

// ### edrc_sva.sv
/*
 * Checker for the request link and the chunk handshake of the request core.
 * Assumes it sits beside the link interface, every signal on core_clk.
 */
`timescale 1ns/1ps
module edrc_sva (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [15:0] burst_request_lines,
    input wire logic [15:0] single_request_lines,
    input wire logic [15:0] last_burst_request_lines,
    input wire logic [15:0] last_single_request_lines,
    input wire logic [15:0] request_acknowledge_lines,
    input wire logic [15:0] terminal_count_lines,
    input wire logic mst_req,
    input wire logic [2:0] mst_ch,
    input wire logic [2:0] mst_len,
    input wire logic mst_done
);
    wire [15:0] ack = request_acknowledge_lines;
    wire [15:0] brq = burst_request_lines | last_burst_request_lines;
    wire [15:0] srq = single_request_lines | last_single_request_lines;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);

    // ********
    // Link
    // ********
    ack_pulse_a: assert property ((ack != 16'h0000) |=> (ack & $past(ack)) == 16'h0000)
        else $error("ack too long");
    ack_cause_a: assert property ((ack != 16'h0000) |-> $past(mst_done))
        else $error("ack without chunk end");
    tc_with_ack_a: assert property ((terminal_count_lines & ~ack) == 16'h0000)
        else $error("tc without ack");
    reserved_quiet_a: assert property (ack[15:10] == 6'h00)
        else $error("ack on reserved lane");
    burst_only_a: assert property ((ack[9:6] & srq[9:6] & ~brq[9:6]) == 4'h0)
        else $error("single served on burst lane");

    // ********
    // Master
    // ********
    chunk_size_a: assert property (mst_req |-> mst_len >= 3'h1 && mst_len <= 3'h4)
        else $error("bad chunk size");
    chunk_hold_a: assert property (mst_req && !mst_done |=> mst_req && $stable(mst_ch) && $stable(mst_len))
        else $error("chunk changed early");
    chunk_gap_a: assert property (mst_req && mst_done |=> !mst_req [*2])
        else $error("next chunk too soon");
endmodule : edrc_sva

// ### test_eight_channel_dma_request_core.sv
/*
 * Testbench: core and peripheral end joined by the link, with a chunk master model.
 * Assumes one 100 MHz clock; inputs change at the falling edge.
 */
`timescale 1ns/1ps
`define CHK(g, e, m) \
    checks++; \
    if ((g) !== (e)) \
    begin \
        n_fail++; \
        $display("unexpected at %0t: %s", $time, m); \
    end
module test_eight_channel_dma_request_core;
    import edrc_pkg::*;
    logic core_clk, rstn, reg_wr, reg_rd, ch_m2m, mst_req, dma_irq, err_next, slow;
    logic mst_done = 1'b0;
    logic mst_err = 1'b0;
    logic [11:0] reg_addr, ch_count;
    logic [31:0] reg_wdata, reg_rdata, sv;
    logic [7:0] ch_start, tc_mask, err_mask, exp_tc, exp_err, exp_en;
    logic [3:0] ch_periph, ch_burst_len;
    logic [2:0] mst_ch, mst_len;
    logic [2:0] ch_q[$];
    logic [15:0] want_burst, want_single, mark_last, req_done, tc_seen;
    int items[8], tc_cnt[16], done_cnt[16];
    int checks = 0, n_fail = 0, dly = 0;

    edrc_if link();
    edrc_core u_edrc_core (.core_clk, .rstn, .link, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
        .reg_rdata, .ch_start, .ch_count, .ch_periph, .ch_m2m, .ch_burst_len, .tc_mask, .err_mask,
        .mst_req, .mst_ch, .mst_len, .mst_done, .mst_err, .dma_irq);
    edrc_periph u_edrc_periph (.core_clk, .rstn, .link, .want_burst, .want_single,
        .mark_last, .req_done, .tc_seen);
    edrc_sva u_edrc_sva (.core_clk, .rstn, .burst_request_lines(link.burst_request_lines),
        .single_request_lines(link.single_request_lines),
        .last_burst_request_lines(link.last_burst_request_lines),
        .last_single_request_lines(link.last_single_request_lines),
        .request_acknowledge_lines(link.request_acknowledge_lines),
        .terminal_count_lines(link.terminal_count_lines), .mst_req, .mst_ch, .mst_len, .mst_done);

    // ********
    // Clock, master model, lane counters
    // ********
    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // Random latency; slow mode lets a rival arrive mid-chunk
    always @(negedge core_clk)
    begin
        if (mst_req && !mst_done && dly == 0)
        begin
            mst_done = 1'b1;
            mst_err = err_next;
            items[mst_ch] += mst_len;
            ch_q.push_back(mst_ch);
        end
        else
        begin
            dly = (mst_req && !mst_done) ? dly - 1 : (slow ? 6 : $urandom % 3);
            mst_done = 1'b0;
            mst_err = 1'b0;
        end
    end

    always @(negedge core_clk)
    begin
        for (int l = 0; l < 16; l++)
        begin
            tc_cnt[l] += tc_seen[l];
            done_cnt[l] += req_done[l];
        end
    end

    // ********
    // Tasks
    // ********
    task automatic wr(logic [11:0] a, logic [31:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge core_clk);
        reg_wr = 1'b0;
        @(negedge core_clk);
    endtask : wr

    task automatic rchk(logic [11:0] a, logic [31:0] e);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge core_clk);
        reg_rd = 1'b0;
        @(negedge core_clk);
        `CHK(reg_rdata, e, "register read")
    endtask : rchk

    task automatic chk_reset();
        for (int a = 0; a <= 48; a += 4)
            rchk(12'(a), 32'h0);
        $display("test reset done");
    endtask : chk_reset

    task automatic chk_status();
        logic [7:0] m;
        tc_mask = $urandom;
        err_mask = $urandom;
        m = (exp_tc & tc_mask) | (exp_err & err_mask);
        rchk(EDRC_RAW_TC_STATUS, {24'h0, exp_tc});
        rchk(EDRC_RAW_ERROR_STATUS, {24'h0, exp_err});
        rchk(EDRC_MASKED_TC_STATUS, {24'h0, exp_tc & tc_mask});
        rchk(EDRC_MASKED_ERROR_STATUS, {24'h0, exp_err & err_mask});
        rchk(EDRC_MASKED_IRQ_STATUS, {24'h0, m});
        rchk(EDRC_ENABLED_CHANNELS, {24'h0, exp_en});
        `CHK(dma_irq, |m, "irq")
    endtask : chk_status

    task automatic clr();
        logic [7:0] m;
        m = $urandom;
        wr(EDRC_TC_REQUEST_CLEAR, {24'h0, m});
        wr(EDRC_ERROR_REQUEST_CLEAR, {24'h0, ~m});
        exp_tc = exp_tc & ~m;
        exp_err = exp_err & m;
        chk_status();
    endtask : clr

    task automatic start_ch(int ch, int cnt, int lane, bit m2m, int bl);
        ch_count = cnt[11:0];
        ch_periph = lane[3:0];
        ch_m2m = m2m;
        ch_burst_len = bl[3:0];
        ch_start = 8'h01 << ch;
        @(negedge core_clk);
        ch_start = 8'h00;
        exp_en[ch] = 1'b1;
        @(negedge core_clk);
    endtask : start_ch

    task automatic do_req(int ch, int lane, bit bst, bit lst, int n, bit tc, bit e);
        int d0 = done_cnt[lane];
        int t0 = tc_cnt[lane];
        items[ch] = 0;
        {want_burst[lane], want_single[lane], mark_last[lane]} = {bst, ~bst, lst};
        for (int i = 0; i < 400 && done_cnt[lane] == d0; i++)
            @(negedge core_clk);
        {want_burst[lane], want_single[lane], mark_last[lane]} = 3'b000;
        `CHK(items[ch], n, "items moved")
        `CHK(done_cnt[lane] - d0, 1, "acknowledge")
        `CHK(tc_cnt[lane] - t0, int'(tc), "terminal count")
        exp_en[ch] = exp_en[ch] & ~(tc | e);
        exp_tc[ch] = exp_tc[ch] | tc;
        exp_err[ch] = exp_err[ch] | e;
    endtask : do_req

    task automatic stop_test();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : stop_test

    initial
    begin
        repeat (40000) @(posedge core_clk);
        n_fail++;
        stop_test();
    end

    // ********
    // Main sequence
    // ********
    initial
    begin
        int ch, lane, bl, rem, n;
        bit bst, lst;
        {reg_addr, reg_wr, reg_rd, reg_wdata, ch_start, ch_count, ch_periph, ch_m2m, ch_burst_len} = '0;
        {tc_mask, err_mask, want_burst, want_single, mark_last, err_next, slow} = '0;
        {exp_tc, exp_err, exp_en, sv} = '0;
        rstn = 1'b0;
        void'($urandom(32'h10c5b56c));
        repeat (12) @(negedge core_clk);
        rstn = 1'b1;
        chk_reset();
        // Reserved lanes only: no transfer starts
        for (int i = 0; i < 3; i++)
        begin
            sv = $urandom & 32'hfffffc00;
            wr(EDRC_SOFT_BURST_REQUEST + 12'(4 * i), sv);
            rchk(EDRC_SOFT_BURST_REQUEST + 12'(4 * i), sv & 32'h0000fc00);
        end
        wr(EDRC_RAW_TC_STATUS, $urandom);
        rchk(EDRC_RAW_TC_STATUS, 32'h0);
        $display("test registers done");
        for (int k = 0; k < 5; k++)
        begin
            ch = 1 + $urandom % 6;
            lane = $urandom % 10;
            bl = $urandom % 16;
            rem = 1 + $urandom % 20;
            start_ch(ch, rem, lane, 1'b0, bl);
            do
            begin
                bst = lane > 5 || $urandom % 2;
                lst = $urandom % 5 == 0;
                n = !bst ? 1 : (bl == 0 ? 1 : bl);
                n = n > rem ? rem : n;
                rem -= n;
                do_req(ch, lane, bst, lst, n, lst || rem == 0, 1'b0);
            end while (!lst && rem > 0);
            chk_status();
        end
        clr();
        $display("test random done");
        items[2] = 0;
        n = tc_cnt[3];
        start_ch(2, 9, 3, 1'b0, 2);
        wr(EDRC_SOFT_LAST_BURST_REQUEST, sv | 32'h8);
        for (int i = 0; i < 300 && tc_cnt[3] == n; i++)
            @(negedge core_clk);
        `CHK(items[2], 2, "soft items")
        rchk(EDRC_SOFT_LAST_BURST_REQUEST, sv & 32'h0000fc00);
        exp_tc[2] = 1'b1;
        exp_en[2] = 1'b0;
        $display("test soft done");
        slow = 1'b1;
        start_ch(7, 8, 6, 1'b0, 8);
        start_ch(0, 4, 1, 1'b0, 4);
        ch_q = {};
        items = '{default: 0};
        want_burst[6] = 1'b1;
        for (int i = 0; i < 100 && mst_req !== 1'b1; i++)
            @(negedge core_clk);
        want_burst[1] = 1'b1;
        for (int i = 0; i < 400 && items[7] + items[0] < 12; i++)
            @(negedge core_clk);
        repeat (3) @(negedge core_clk);
        want_burst = 16'h0000;
        slow = 1'b0;
        `CHK(ch_q[0], 3'h7, "first chunk")
        `CHK(ch_q[1], 3'h0, "preempting chunk")
        `CHK(items[7] + items[0], 12, "priority items")
        exp_tc = exp_tc | 8'h81;
        exp_en = exp_en & 8'h7e;
        chk_status();
        $display("test priority done");
        start_ch(3, 8, 4, 1'b0, 4);
        err_next = 1'b1;
        do_req(3, 4, 1'b1, 1'b0, 4, 1'b0, 1'b1);
        err_next = 1'b0;
        chk_status();
        clr();
        $display("test error done");
        items[7] = 0;
        n = tc_cnt[2] + done_cnt[2];
        start_ch(7, 6, 2, 1'b1, 2);
        for (int i = 0; i < 300 && items[7] < 6; i++)
            @(negedge core_clk);
        `CHK(items[7], 6, "copy items")
        `CHK(tc_cnt[2] + done_cnt[2], n, "copy handshake")
        exp_tc[7] = 1'b1;
        exp_en[7] = 1'b0;
        chk_status();
        items = '{default: 0};
        start_ch(4, 4, 12, 1'b0, 4);
        start_ch(6, 4, 7, 1'b0, 1);
        want_burst[12] = 1'b1;
        want_single[7] = 1'b1;
        repeat (60) @(negedge core_clk);
        `CHK(items[4] + items[6], 0, "reserved lanes")
        chk_status();
        {want_burst, want_single} = '0;
        $display("test lanes done");
        rstn = 1'b0;
        repeat (12) @(negedge core_clk);
        rstn = 1'b1;
        chk_reset();
        stop_test();
    end
endmodule : test_eight_channel_dma_request_core
